// [core/cad_top.sv]
// Purpose: Low-pressure, flow and thermal switch alarm diagnostics
// Assumes: Switch pins asynchronous, run requests on sys_clk
// Notes:   All timers share one seconds tick; bypass restarts on each start
// Summary of operation
// - Ignore low pressure during compressor bypass
// - Low-pressure events over limit force manual
// - Hold off flow checks during pump bypass
// - Flow alarm after continuous active time
// - Active timer starts after bypass expires
// - Inactive time needed before flow clears
// - Flow alarms over limit force manual
// - Manual flow alarm stops the pump
// - Copy card needs correct password
// - Thermal checks wait after compressor start
`timescale 1ns/1ns
`include "cad_cfg.svh"

// ----------------------------------------
// Saturating seconds counter
// ----------------------------------------
module cad_secctr #(
    parameter int W = 16
) (
    input  wire logic         sys_clk,
    input  wire logic         reset_n,
    input  wire logic         en,
    input  wire logic         tick,
    input  wire logic [W-1:0] limit,
    output logic              done
);
    logic [W-1:0] cnt_ff;
    // Restart whenever the enable drops
    always_ff @(posedge sys_clk) begin
        if (!reset_n || !en)
            cnt_ff <= '0;
        else if (tick && cnt_ff < limit)
            cnt_ff <= cnt_ff + 1'b1;
    end
    assign done = en && (cnt_ff >= limit);
endmodule : cad_secctr
// ----------------------------------------
// Sliding one-hour event window
// ----------------------------------------
module cad_evwin #(
    parameter int DEPTH = 16
) (
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic [11:0] now,
    input  wire logic        evt,
    output logic [7:0]       count
);
    logic [11:0]      stamp_ff [DEPTH];
    logic [DEPTH-1:0] valid_ff;
    logic [DEPTH-1:0] keep;
    // drop old events
    // Stamps wrap at 4096 s, safe as entries expire at 3600 s
    always_comb begin
        for (int i = 0; i < DEPTH; i++)
            keep[i] = valid_ff[i] && (12'(now - stamp_ff[i]) < `CAD_WINDOW_SEC);
    end
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            valid_ff <= '0;
            for (int i = 0; i < DEPTH; i++)
                stamp_ff[i] <= 12'h000;
        end else if (evt) begin
            valid_ff <= {keep[DEPTH-2:0], 1'b1};
            stamp_ff[0] <= now;
            for (int i = 1; i < DEPTH; i++)
                stamp_ff[i] <= stamp_ff[i-1];
        end else begin
            valid_ff <= keep;
        end
    end
    // Count saturates at DEPTH; limits must not exceed it
    always_comb begin
        count = 8'h00;
        for (int i = 0; i < DEPTH; i++)
            count = count + 8'(valid_ff[i]);
    end
endmodule : cad_evwin
// ----------------------------------------
// Top level
// ----------------------------------------
module cad_top #(
    parameter int TICK_CYCLES = `CAD_SEC_NS / `CAD_CLK_NS,
    parameter int EV_DEPTH    = 16
) (
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata_ff,
    input  wire logic        comp_req,
    input  wire logic        pump_req,
    input  wire logic        lp_switch,
    input  wire logic        flow_switch,
    input  wire logic        thermal_switch,
    input  wire logic        copy_req,
    output logic             comp_out_ff,
    output logic             pump_out_ff,
    output logic             copy_go_ff,
    output logic             irq_ff
);
    cad_pkg::cad_param_s           par_ff;
    cad_pkg::cad_alarm_s           al_ff;
    logic [2:0]                    s1_ff, s2_ff, s3_ff, pin_ff;
    logic [24:0]                   div_ff;
    logic [11:0]                   sec_ff;
    logic [`CAD_IRQ_W-1:0]         ist_ff, imask_ff;
    logic [7:0]                    lp_cnt, fl_cnt;
    logic tick, lp_act, fl_act, th_act, rst_cmd, lock_cmd, pw_wr;
    logic lp_byp_done, fl_byp_done, fl_act_done, fl_inact_done, th_byp_done;
    logic lp_set, fl_set, th_set, lp_to_man, fl_to_man;
    logic [`CAD_IRQ_W-1:0]         ev_vec;
    logic [31:0]                   rd_mux;
    // ----------------------------------------
    // Pin synchronisers and seconds tick
    // ----------------------------------------
    // Three stages; a level counts once stages two and three agree
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            s1_ff  <= 3'h0;
            s2_ff  <= 3'h0;
            s3_ff  <= 3'h0;
            pin_ff <= 3'h0;
        end else begin
            s1_ff  <= {thermal_switch, flow_switch, lp_switch};
            s2_ff  <= s1_ff;
            s3_ff  <= s2_ff;
            pin_ff <= (s2_ff & ~(s2_ff ^ s3_ff)) | (pin_ff & (s2_ff ^ s3_ff));
        end
    end
    assign lp_act = pin_ff[0];
    assign fl_act = pin_ff[1];
    assign th_act = pin_ff[2];
    assign tick   = (div_ff == 25'(TICK_CYCLES - 1));
    // One-second enable pulse and free seconds stamp
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            div_ff <= 25'h0;
            sec_ff <= 12'h000;
        end else begin
            div_ff <= tick ? 25'h0 : div_ff + 1'b1;
            sec_ff <= tick ? sec_ff + 1'b1 : sec_ff;
        end
    end
    // ----------------------------------------
    // Timers
    // ----------------------------------------
    // low-pressure bypass
    cad_secctr u_lp_byp (.sys_clk(sys_clk), .reset_n(reset_n), .en(comp_out_ff),
        .tick(tick), .limit(par_ff.lp_bypass_time), .done(lp_byp_done));
    cad_secctr u_fl_byp (.sys_clk(sys_clk), .reset_n(reset_n), .en(pump_out_ff),
        .tick(tick), .limit(par_ff.flow_bypass_time), .done(fl_byp_done));
    cad_secctr u_fl_act (.sys_clk(sys_clk), .reset_n(reset_n),
        .en(fl_byp_done && fl_act), .tick(tick),
        .limit(par_ff.flow_active_time), .done(fl_act_done));
    cad_secctr u_fl_ina (.sys_clk(sys_clk), .reset_n(reset_n), .en(!fl_act),
        .tick(tick), .limit(par_ff.flow_inactive_time), .done(fl_inact_done));
    cad_secctr u_th_byp (.sys_clk(sys_clk), .reset_n(reset_n), .en(comp_out_ff),
        .tick(tick), .limit(par_ff.thermal_bypass_time), .done(th_byp_done));
    // ----------------------------------------
    // Event windows and alarm decisions
    // ----------------------------------------
    // hourly event counts
    cad_evwin #(.DEPTH(EV_DEPTH)) u_lp_win (.sys_clk(sys_clk), .reset_n(reset_n),
        .now(sec_ff), .evt(lp_set), .count(lp_cnt));
    cad_evwin #(.DEPTH(EV_DEPTH)) u_fl_win (.sys_clk(sys_clk), .reset_n(reset_n),
        .now(sec_ff), .evt(fl_set), .count(fl_cnt));
    assign fl_set    = fl_act_done && !al_ff.flow_alarm;
    assign lp_set    = lp_byp_done && lp_act && !al_ff.lp_alarm;
    assign th_set    = th_byp_done && th_act && !al_ff.thermal_alarm;
    assign lp_to_man = lp_set && (9'(lp_cnt) + 9'h001 > 9'(par_ff.lp_events_per_hour));
    assign fl_to_man = fl_set && (9'(fl_cnt) + 9'h001 > 9'(par_ff.flow_alarms_per_hour));
    assign ev_vec    = {th_set, fl_to_man, lp_to_man, fl_set, lp_set};
    // auto clear or command
    // Manual state set wins over a reset command in the same cycle
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            al_ff <= '0;
        end else begin
            al_ff.lp_alarm      <= lp_set || (al_ff.lp_alarm &&
                                   (al_ff.lp_manual ? !rst_cmd : lp_act));
            al_ff.lp_manual     <= lp_to_man || (al_ff.lp_manual && !rst_cmd);
            al_ff.flow_alarm    <= fl_set || (al_ff.flow_alarm &&
                                   (al_ff.flow_manual ? !rst_cmd : !fl_inact_done));
            al_ff.flow_manual   <= fl_to_man || (al_ff.flow_manual && !rst_cmd);
            al_ff.thermal_alarm <= th_set || (al_ff.thermal_alarm && th_act);
            al_ff.copy_unlocked <= pw_wr ? (reg_wdata[15:0] == par_ff.password)
                                 : (al_ff.copy_unlocked && !lock_cmd);
        end
    end
    // ----------------------------------------
    // Actuator and copy outputs
    // ----------------------------------------
    // pump stop on manual
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            comp_out_ff <= 1'b0;
            pump_out_ff <= 1'b0;
            copy_go_ff  <= 1'b0;
        end else begin
            comp_out_ff <= comp_req && !al_ff.lp_alarm && !al_ff.thermal_alarm;
            pump_out_ff <= pump_req && !al_ff.flow_manual && !fl_to_man;
            copy_go_ff  <= copy_req && al_ff.copy_unlocked;
        end
    end
    // ----------------------------------------
    // Register file and interrupt
    // ----------------------------------------
    assign rst_cmd  = reg_wr && reg_addr == `CAD_OFS_CTRL && reg_wdata[`CAD_CTRL_RESET];
    assign lock_cmd = reg_wr && reg_addr == `CAD_OFS_CTRL && reg_wdata[`CAD_CTRL_LOCK];
    assign pw_wr    = reg_wr && reg_addr == `CAD_OFS_PW_ENTRY;
    // Parameter writes take the low bits only
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            par_ff <= {`CAD_RST_TIME, `CAD_RST_COUNT, `CAD_RST_TIME, `CAD_RST_TIME,
                       `CAD_RST_TIME, `CAD_RST_COUNT, `CAD_RST_TIME, `CAD_RST_PW};
        end else if (reg_wr) begin
            case (reg_addr)
                `CAD_OFS_LP_BYP:   par_ff.lp_bypass_time       <= reg_wdata[15:0];
                `CAD_OFS_LP_EPH:   par_ff.lp_events_per_hour   <= reg_wdata[7:0];
                `CAD_OFS_FL_BYP:   par_ff.flow_bypass_time     <= reg_wdata[15:0];
                `CAD_OFS_FL_ACT:   par_ff.flow_active_time     <= reg_wdata[15:0];
                `CAD_OFS_FL_INACT: par_ff.flow_inactive_time   <= reg_wdata[15:0];
                `CAD_OFS_FL_APH:   par_ff.flow_alarms_per_hour <= reg_wdata[7:0];
                `CAD_OFS_TH_BYP:   par_ff.thermal_bypass_time  <= reg_wdata[15:0];
                `CAD_OFS_PASSWORD: par_ff.password             <= reg_wdata[15:0];
                default:           par_ff                      <= par_ff;
            endcase
        end
    end
    // Sticky events; a new event beats a write-one clear
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ist_ff   <= '0;
            imask_ff <= '0;
            irq_ff   <= 1'b0;
        end else begin
            ist_ff   <= ev_vec | (ist_ff & ~((reg_wr && reg_addr == `CAD_OFS_IRQ_STAT)
                        ? reg_wdata[`CAD_IRQ_W-1:0] : '0));
            imask_ff <= (reg_wr && reg_addr == `CAD_OFS_IRQ_MASK)
                        ? reg_wdata[`CAD_IRQ_W-1:0] : imask_ff;
            irq_ff   <= |(ist_ff & imask_ff);
        end
    end
    // Password is write-only so it never leaks back
    assign rd_mux =
        reg_addr == `CAD_OFS_LP_BYP   ? {16'h0, par_ff.lp_bypass_time} :
        reg_addr == `CAD_OFS_LP_EPH   ? {24'h0, par_ff.lp_events_per_hour} :
        reg_addr == `CAD_OFS_FL_BYP   ? {16'h0, par_ff.flow_bypass_time} :
        reg_addr == `CAD_OFS_FL_ACT   ? {16'h0, par_ff.flow_active_time} :
        reg_addr == `CAD_OFS_FL_INACT ? {16'h0, par_ff.flow_inactive_time} :
        reg_addr == `CAD_OFS_FL_APH   ? {24'h0, par_ff.flow_alarms_per_hour} :
        reg_addr == `CAD_OFS_TH_BYP   ? {16'h0, par_ff.thermal_bypass_time} :
        reg_addr == `CAD_OFS_STATUS   ? {8'h0, fl_cnt, lp_cnt, 2'h0, al_ff} :
        reg_addr == `CAD_OFS_IRQ_STAT ? {27'h0, ist_ff} :
        reg_addr == `CAD_OFS_IRQ_MASK ? {27'h0, imask_ff} : 32'h0;
    // Read data valid only in the cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (!reset_n)
            reg_rdata_ff <= 32'h0;
        else
            reg_rdata_ff <= reg_rd ? rd_mux : 32'h0;
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_lp_bypass;
        @(posedge sys_clk) disable iff (!reset_n)
        $rose(al_ff.lp_alarm) |-> $past(lp_byp_done) && $past(lp_act);
    endproperty
    a_lp_bypass: assert property (p_lp_bypass) else $error("lp alarm in bypass");
    property p_lp_manual;
        @(posedge sys_clk) disable iff (!reset_n)
        lp_to_man |=> al_ff.lp_manual && al_ff.lp_alarm;
    endproperty
    a_lp_manual: assert property (p_lp_manual) else $error("lp not manual");
    property p_fl_bypass;
        @(posedge sys_clk) disable iff (!reset_n)
        $rose(al_ff.flow_alarm) |-> $past(fl_byp_done);
    endproperty
    a_fl_bypass: assert property (p_fl_bypass) else $error("flow alarm in bypass");
    property p_fl_active;
        @(posedge sys_clk) disable iff (!reset_n)
        $rose(al_ff.flow_alarm) |-> $past(fl_act) && $past(fl_act_done);
    endproperty
    a_fl_active: assert property (p_fl_active) else $error("flow alarm early");
    property p_fl_order;
        @(posedge sys_clk) disable iff (!reset_n)
        !fl_byp_done |-> !fl_act_done;
    endproperty
    a_fl_order: assert property (p_fl_order) else $error("active timer in bypass");
    property p_fl_inact;
        @(posedge sys_clk) disable iff (!reset_n)
        $fell(al_ff.flow_alarm) && !$past(al_ff.flow_manual) |-> $past(fl_inact_done);
    endproperty
    a_fl_inact: assert property (p_fl_inact) else $error("flow cleared early");
    property p_fl_manual;
        @(posedge sys_clk) disable iff (!reset_n)
        fl_set && (fl_cnt >= par_ff.flow_alarms_per_hour) |=> al_ff.flow_manual;
    endproperty
    a_fl_manual: assert property (p_fl_manual) else $error("flow not manual");
    property p_pump_off;
        @(posedge sys_clk) disable iff (!reset_n)
        al_ff.flow_manual |=> !pump_out_ff;
    endproperty
    a_pump_off: assert property (p_pump_off) else $error("pump on while manual");
    property p_copy;
        @(posedge sys_clk) disable iff (!reset_n)
        copy_go_ff |-> $past(al_ff.copy_unlocked) && $past(copy_req);
    endproperty
    a_copy: assert property (p_copy) else $error("copy without password");
    property p_th_bypass;
        @(posedge sys_clk) disable iff (!reset_n)
        $rose(al_ff.thermal_alarm) |-> $past(th_byp_done);
    endproperty
    a_th_bypass: assert property (p_th_bypass) else $error("thermal in bypass");
    property p_latch;
        @(posedge sys_clk) disable iff (!reset_n)
        al_ff.lp_manual && !rst_cmd |=> al_ff.lp_alarm && al_ff.lp_manual;
    endproperty
    a_latch: assert property (p_latch) else $error("manual alarm dropped");
endmodule : cad_top

// [core/cad_cfg.svh]
// Purpose: Constants for the chiller alarm diagnostics block
// Assumes: 20 MHz sys_clk, one-second timebase
// Notes:   Offsets are byte addresses of 32-bit words
`ifndef CAD_CFG_SVH
`define CAD_CFG_SVH
// ----------------------------------------
// Timing
// ----------------------------------------
`define CAD_SEC_NS        1000000000
`define CAD_CLK_NS        50
`define CAD_WINDOW_SEC    12'd3600
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CAD_OFS_CTRL      8'h00
`define CAD_OFS_LP_BYP    8'h04
`define CAD_OFS_LP_EPH    8'h08
`define CAD_OFS_FL_BYP    8'h0c
`define CAD_OFS_FL_ACT    8'h10
`define CAD_OFS_FL_INACT  8'h14
`define CAD_OFS_FL_APH    8'h18
`define CAD_OFS_TH_BYP    8'h1c
`define CAD_OFS_PASSWORD  8'h20
`define CAD_OFS_PW_ENTRY  8'h24
`define CAD_OFS_STATUS    8'h28
`define CAD_OFS_IRQ_STAT  8'h2c
`define CAD_OFS_IRQ_MASK  8'h30
// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define CAD_CTRL_RESET    0
`define CAD_CTRL_LOCK     1
`define CAD_IRQ_W         5
`define CAD_RST_TIME      16'h000a
`define CAD_RST_COUNT     8'h05
`define CAD_RST_PW        16'h0000
`endif

// [core/cad_pkg.sv]
// Purpose: Types for the chiller alarm diagnostics block
// Assumes: Nothing beyond the config header
// Notes:   Times are in seconds, counts in events per hour
package cad_pkg;
    // Software-set parameters of the diagnostics
    typedef struct packed {
        logic [15:0] lp_bypass_time;
        logic [7:0]  lp_events_per_hour;
        logic [15:0] flow_bypass_time;
        logic [15:0] flow_active_time;
        logic [15:0] flow_inactive_time;
        logic [7:0]  flow_alarms_per_hour;
        logic [15:0] thermal_bypass_time;
        logic [15:0] password;
    } cad_param_s;
    // Alarm state as shown to software
    typedef struct packed {
        logic copy_unlocked;
        logic thermal_alarm;
        logic flow_manual;
        logic flow_alarm;
        logic lp_manual;
        logic lp_alarm;
    } cad_alarm_s;
endpackage : cad_pkg

// [testbench/cad_plant.sv]
// Purpose: Switch side of the chiller plant seen by the diagnostics
// Assumes: Faults are commanded by the bench
// Notes:   Pins are active high on fault, with a contact lag
`timescale 1ns/1ns
module cad_plant #(
    parameter int LAG_NS = 7
) (
    input  wire logic lp_fault,
    input  wire logic flow_fault,
    input  wire logic th_fault,
    output logic      lp_switch,
    output logic      flow_switch,
    output logic      thermal_switch
);
    // ----------------------------------------
    // Switch contacts
    // ----------------------------------------
    // Lag keeps contact changes off the clock edge
    assign #LAG_NS lp_switch      = lp_fault;
    assign #LAG_NS flow_switch    = flow_fault;
    assign #LAG_NS thermal_switch = th_fault;
endmodule : cad_plant

// [testbench/cad_top_bench.sv]
// Purpose: Self-checking bench for the alarm diagnostics
// Assumes: One second shortened to TK clock cycles
// Notes:   Checks allow for tick phase and pin synchronisers
`timescale 1ns/1ns
`include "cad_cfg.svh"
module cad_top_bench;
    localparam int TK = 10;
    logic        sys_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata_ff;
    logic        comp_req = 1'b0;
    logic        pump_req = 1'b0;
    logic        copy_req = 1'b0;
    logic        lp_fault = 1'b0;
    logic        flow_fault = 1'b0;
    logic        th_fault = 1'b0;
    logic        lp_switch;
    logic        flow_switch;
    logic        thermal_switch;
    logic        comp_out_ff;
    logic        pump_out_ff;
    logic        copy_go_ff;
    logic        irq_ff;
    int          error_cnt = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    logic [31:0] s;

    // ----------------------------------------
    // Design and plant
    // ----------------------------------------
    cad_top #(.TICK_CYCLES(TK), .EV_DEPTH(16)) uut (
        .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata_ff(reg_rdata_ff), .comp_req(comp_req), .pump_req(pump_req),
        .lp_switch(lp_switch), .flow_switch(flow_switch),
        .thermal_switch(thermal_switch), .copy_req(copy_req),
        .comp_out_ff(comp_out_ff), .pump_out_ff(pump_out_ff),
        .copy_go_ff(copy_go_ff), .irq_ff(irq_ff));
    cad_plant #(.LAG_NS(7)) plant (
        .lp_fault(lp_fault), .flow_fault(flow_fault), .th_fault(th_fault),
        .lp_switch(lp_switch), .flow_switch(flow_switch),
        .thermal_switch(thermal_switch));

    // ----------------------------------------
    // Clock, timeout and helpers
    // ----------------------------------------
    // 20 MHz clock
    always #25 sys_clk = ~sys_clk;
    // Ceiling covers the one-hour window wait plus margin
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 50000) begin
            error_cnt++;
            $display("unexpected timeout at %0t: got %h expected %h", $time, cyc, 0);
            close_out();
        end
    end
    task automatic close_out();
        $display("errors %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : close_out
    task automatic tk(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : tk
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk1(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask : chk1
    // Bus cycles: one strobe cycle each, data the cycle after a read
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        // Data stands one cycle; take it at that cycle's closing edge
        @(posedge sys_clk);
        d = reg_rdata_ff;
    endtask : rd
    task automatic chkreg(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd(a, d);
        chk(d, e);
    endtask : chkreg
    task automatic stb(input int b, input logic e);
        logic [31:0] d;
        rd(`CAD_OFS_STATUS, d);
        chk1(d[b], e);
    endtask : stb
    task automatic rst();
        @(posedge sys_clk);
        reset_n <= 1'b0;
        comp_req <= 1'b0;
        pump_req <= 1'b0;
        copy_req <= 1'b0;
        lp_fault <= 1'b0;
        flow_fault <= 1'b0;
        th_fault <= 1'b0;
        tk(10);
        reset_n <= 1'b1;
    endtask : rst

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    // Reset values, unmapped place, read data lasting one cycle
    task automatic t_regs();
        chkreg(`CAD_OFS_LP_BYP, 32'h0000000a);
        chkreg(`CAD_OFS_LP_EPH, 32'h00000005);
        chkreg(`CAD_OFS_PASSWORD, 32'h00000000);
        wr(8'h40, 32'hffffffff);
        chkreg(8'h40, 32'h00000000);
        wr(`CAD_OFS_FL_ACT, 32'h00000007);
        chkreg(`CAD_OFS_FL_ACT, 32'h00000007);
        @(posedge sys_clk);
        chk(reg_rdata_ff, 32'h00000000);
    endtask : t_regs
    task automatic t_lp_bypass();
        rst();
        wr(`CAD_OFS_LP_BYP, 32'h00000003);
        lp_fault <= 1'b1;
        comp_req <= 1'b1;
        tk(18);
        chk1(comp_out_ff, 1'b1);
        tk(40);
        chk1(comp_out_ff, 1'b0);
        stb(0, 1'b1);
        lp_fault <= 1'b0;
        tk(10);
        stb(0, 1'b0);
    endtask : t_lp_bypass
    // Third event in the hour passes a limit of two
    task automatic t_lp_manual();
        rst();
        wr(`CAD_OFS_LP_BYP, 32'h00000000);
        wr(`CAD_OFS_LP_EPH, 32'h00000002);
        comp_req <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            lp_fault <= 1'b1;
            tk(10);
            stb(0, 1'b1);
            lp_fault <= 1'b0;
            tk(10);
            stb(1, i == 2);
        end
        chkreg(`CAD_OFS_IRQ_STAT, 32'h00000005);
        rd(`CAD_OFS_STATUS, s);
        chk({24'h0, s[15:8]}, 32'h00000003);
        comp_req <= 1'b0;
        tk(3600 * TK + 100);
        rd(`CAD_OFS_STATUS, s);
        chk({24'h0, s[15:8]}, 32'h00000000);
        stb(1, 1'b1);
        wr(`CAD_OFS_CTRL, 32'h00000001);
        stb(1, 1'b0);
    endtask : t_lp_manual
    task automatic t_flow();
        rst();
        wr(`CAD_OFS_FL_BYP, 32'h00000004);
        wr(`CAD_OFS_FL_ACT, 32'h00000004);
        wr(`CAD_OFS_FL_INACT, 32'h00000003);
        pump_req <= 1'b1;
        flow_fault <= 1'b1;
        tk(50);
        stb(2, 1'b0);
        tk(60);
        stb(2, 1'b1);
        flow_fault <= 1'b0;
        tk(12);
        stb(2, 1'b1);
        tk(40);
        stb(2, 1'b0);
    endtask : t_flow
    // Second flow alarm passes a limit of one and stops the pump
    task automatic t_flow_manual();
        rst();
        wr(`CAD_OFS_FL_BYP, 32'h00000000);
        wr(`CAD_OFS_FL_ACT, 32'h00000001);
        wr(`CAD_OFS_FL_INACT, 32'h00000001);
        wr(`CAD_OFS_FL_APH, 32'h00000001);
        pump_req <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            flow_fault <= 1'b1;
            tk(30);
            stb(2, 1'b1);
            flow_fault <= 1'b0;
            tk(30);
            stb(3, i == 1);
            chk1(pump_out_ff, i == 0);
        end
        rd(`CAD_OFS_STATUS, s);
        chk({24'h0, s[23:16]}, 32'h00000002);
        chkreg(`CAD_OFS_IRQ_STAT, 32'h0000000a);
        wr(`CAD_OFS_CTRL, 32'h00000001);
        tk(3);
        chk1(pump_out_ff, 1'b1);
    endtask : t_flow_manual
    task automatic t_copy();
        rst();
        copy_req <= 1'b1;
        tk(3);
        chk1(copy_go_ff, 1'b0);
        wr(`CAD_OFS_PASSWORD, 32'h00001234);
        wr(`CAD_OFS_PW_ENTRY, 32'h00001111);
        tk(2);
        chk1(copy_go_ff, 1'b0);
        wr(`CAD_OFS_PW_ENTRY, 32'h00001234);
        tk(2);
        chk1(copy_go_ff, 1'b1);
        stb(5, 1'b1);
        wr(`CAD_OFS_CTRL, 32'h00000002);
        tk(2);
        chk1(copy_go_ff, 1'b0);
        stb(5, 1'b0);
    endtask : t_copy
    // Thermal bypass, then interrupt raise, mask and clear
    task automatic t_thermal_irq();
        rst();
        wr(`CAD_OFS_TH_BYP, 32'h00000003);
        wr(`CAD_OFS_IRQ_MASK, 32'h00000010);
        comp_req <= 1'b1;
        th_fault <= 1'b1;
        tk(16);
        stb(4, 1'b0);
        tk(40);
        stb(4, 1'b1);
        chk1(irq_ff, 1'b1);
        th_fault <= 1'b0;
        tk(10);
        wr(`CAD_OFS_IRQ_MASK, 32'h00000000);
        tk(2);
        chk1(irq_ff, 1'b0);
        wr(`CAD_OFS_IRQ_MASK, 32'h00000010);
        tk(2);
        chk1(irq_ff, 1'b1);
        wr(`CAD_OFS_IRQ_STAT, 32'h00000010);
        tk(2);
        chk1(irq_ff, 1'b0);
        chkreg(`CAD_OFS_IRQ_STAT, 32'h00000000);
    endtask : t_thermal_irq

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rst();
        t_regs();
        t_lp_bypass();
        t_flow();
        t_flow_manual();
        t_copy();
        t_thermal_irq();
        t_lp_manual();
        close_out();
    end
endmodule : cad_top_bench
